// ### lpsw_consts.svh
// constants of the low-power stop/wait controller: offsets, bits, reset values, counts
// assumes inclusion by bare name from the package and the design modules
`ifndef LPSW_CONSTS_SVH
`define LPSW_CONSTS_SVH

// register byte offsets, one aligned 32-bit word each
`define LPSW_ADDR_CTRL 8'h00
`define LPSW_ADDR_PC_DIR 8'h04
`define LPSW_ADDR_PC_TMR 8'h08
`define LPSW_ADDR_STATUS 8'h0C
`define LPSW_ADDR_IRQ_STAT 8'h10
`define LPSW_ADDR_IRQ_MASK 8'h14

// control register bit positions
`define LPSW_CTRL_STOP_DIS 0
`define LPSW_CTRL_IRQ_LEVEL 1
`define LPSW_CTRL_KBD_EN 2
`define LPSW_CTRL_LVI_EN 3
`define LPSW_CTRL_LVI_SOFT 4
`define LPSW_CTRL_CT_EN 5
`define LPSW_CTRL_PT_EN 6

// event bits of status and mask registers
`define LPSW_EV_STOP_ENTER 0
`define LPSW_EV_WAIT_ENTER 1
`define LPSW_EV_STOP_EXIT 2
`define LPSW_EV_WAIT_EXIT 3
`define LPSW_EV_STOP_NOP 4
`define LPSW_EV_W 5

// reset values
`define LPSW_CTRL_RST 8'h00
`define LPSW_PC_DIR_RST 8'h00
`define LPSW_PC_TMR_RST 2'h0
`define LPSW_IRQ_RST 5'h00

// timing: oscillator cycles per bus cycle, stop exit delay in bus cycles
`define LPSW_OSC_PER_BUS 2
`define LPSW_STARTUP_BUS_CYCLES 4064
`define LPSW_CNT_W 13

`endif

// ### lpsw_pkg.sv
// types of the low-power stop/wait controller
// assumes lpsw_consts.svh is on the include path
package lpsw_pkg;
`include "lpsw_consts.svh"

   // sleep control modes
   typedef enum logic [1:0] {st_run, st_wait, st_stop, st_startup} lpsw_mode_t;

   // cause of the last wake-up
   typedef enum logic [2:0] {wk_none, wk_ext, wk_kbd, wk_lvi, wk_ctim, wk_ptim} lpsw_wake_t;

   // whole state of the top module
   typedef struct packed {
      lpsw_mode_t mode;
      logic [`LPSW_CNT_W-1:0] cnt;
      logic [7:0] ctrl;
      logic [7:0] pc_dir;
      logic [1:0] pc_tmr;
      logic [`LPSW_EV_W-1:0] irq_stat;
      logic [`LPSW_EV_W-1:0] irq_mask;
      lpsw_wake_t wake;
      logic pend;
      logic a_wr;
      logic [7:0] a_addr;
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
      logic osc_en;
      logic cpu_halt;
      logic periph_run;
      logic adc_run;
      logic clr_imask;
      logic hold_regs;
      logic cpu_irq;
      logic lvi_soft;
      logic irq;
   } lpsw_state_t;
endpackage

// ### lpsw_bus_div.sv
// bus clock enable: one tick per bus cycle, derived from the oscillator clock
// assumes core_clk is the oscillator clock; run low stands the divider still
`timescale 1ns/1ps
`include "lpsw_consts.svh"
module lpsw_bus_div
   import lpsw_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   // control and tick
   input wire logic run,
   output logic bus_tick
);
   typedef struct packed {
      logic [1:0] cnt;
   } lpsw_div_t;

   lpsw_div_t s_q;
   lpsw_div_t s_d;

   // divide by the oscillator-per-bus ratio; restart at zero after the oscillator stops
   always_comb begin
      s_d = s_q;
      if (!run) begin
         s_d.cnt = 2'h0;
      end else if (s_q.cnt == 2'(`LPSW_OSC_PER_BUS - 1)) begin
         s_d.cnt = 2'h0;
      end else begin
         s_d.cnt = s_q.cnt + 2'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_q <= '0;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   // tick on the last oscillator cycle of each bus cycle
   assign bus_tick = run && (s_q.cnt == 2'(`LPSW_OSC_PER_BUS - 1));
endmodule

// ### lpsw_fall_det.sv
// falling edge detector for a group of active-low or idle-high pins
// assumes pins already synchronous to core_clk; idle level high after reset
`timescale 1ns/1ps
module lpsw_fall_det
   import lpsw_pkg::*;
#(
   parameter int W = 1
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   // pins and edges
   input wire logic [W-1:0] pin,
   output logic [W-1:0] fall
);
   typedef struct packed {
      logic [W-1:0] prev;
   } lpsw_fall_t;

   lpsw_fall_t s_q;
   lpsw_fall_t s_d;

   // remember last pin level
   always_comb begin
      s_d = s_q;
      s_d.prev = pin;
   end

   // reset to high, so a pin held low at reset reports one falling edge in the first cycle after reset
   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_q <= '1;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   assign fall = s_q.prev & ~pin;
endmodule

// ### lpsw_ctrl.sv
// low-power stop/wait controller: sleep modes, wake-up selection, stop exit delay
// assumes an AHB-Lite master, pins synchronous to core_clk, core_clk the oscillator clock
//
// Local design decisions: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "lpsw_consts.svh"
module lpsw_ctrl
   import lpsw_pkg::*;
#(
   parameter logic [`LPSW_CNT_W-1:0] STARTUP_BUS_CYCLES = `LPSW_CNT_W'(`LPSW_STARTUP_BUS_CYCLES)
)
(
   // clock, reset, enable
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // cpu instruction strobes
   input wire logic stop_exec,
   input wire logic wait_exec,
   // wake-up pins
   input wire logic irq_pin_n,
   input wire logic low_voltage_indicator_n,
   input wire logic [7:0] portc_pin,
   // peripheral interrupt requests
   input wire logic core_timer_irq,
   input wire logic prog_timer_irq,
   // clock and run controls
   output logic osc_enable,
   output logic cpu_halt,
   output logic periph_run,
   output logic adc_run,
   output logic hold_regs,
   // to the cpu
   output logic clear_imask,
   output logic cpu_irq,
   output logic lvi_soft_req,
   // interrupt to software
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////////////
   // state and decoded requests

   lpsw_state_t s_q;
   lpsw_state_t s_d;
   logic bus_tick;
   logic irq_fall;
   logic lvi_fall;
   logic [7:0] kbd_fall;
   logic [7:0] kbd_ok;
   logic ext_req;
   logic kbd_req;
   logic lvi_req;
   logic ct_req;
   logic pt_req;
   logic wake_stop;
   logic wake_wait;
   logic ord_req;
   logic stop_go;
   logic [`LPSW_EV_W-1:0] ev;
   logic [`LPSW_EV_W-1:0] w1c;
   logic [31:0] rd_val;

   ////////////////////////////////////////////////////////////////////////////////
   // helpers

   // bus cycle tick, stands still while the oscillator is off
   lpsw_bus_div u_div (
      .core_clk(core_clk),
      .rst(rst),
      .clk_en(clk_en),
      .run(s_q.osc_en),
      .bus_tick(bus_tick)
   );

   // edge detectors keep running in stop; the wake path must not need the oscillator
   lpsw_fall_det #(.W(1)) u_irq_det (
      .core_clk(core_clk),
      .rst(rst),
      .clk_en(clk_en),
      .pin(irq_pin_n),
      .fall(irq_fall)
   );

   lpsw_fall_det #(.W(1)) u_lvi_det (
      .core_clk(core_clk),
      .rst(rst),
      .clk_en(clk_en),
      .pin(low_voltage_indicator_n),
      .fall(lvi_fall)
   );

   lpsw_fall_det #(.W(8)) u_kbd_det (
      .core_clk(core_clk),
      .rst(rst),
      .clk_en(clk_en),
      .pin(portc_pin),
      .fall(kbd_fall)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // wake-up sources

   // keyboard pins must be inputs and free of capture (pc0) and compare (pc1)
   assign kbd_ok = ~s_q.pc_dir & ~{6'h00, s_q.pc_tmr};
   assign kbd_req = s_q.ctrl[`LPSW_CTRL_KBD_EN] && ((kbd_fall & kbd_ok) != 8'h00);
   // level mode keeps asking while the pin stays low
   assign ext_req = irq_fall || (s_q.ctrl[`LPSW_CTRL_IRQ_LEVEL] && !irq_pin_n);
   assign lvi_req = s_q.ctrl[`LPSW_CTRL_LVI_EN] && lvi_fall;
   assign ct_req = s_q.ctrl[`LPSW_CTRL_CT_EN] && core_timer_irq;
   assign pt_req = s_q.ctrl[`LPSW_CTRL_PT_EN] && prog_timer_irq;
   // timers are frozen in stop, so only pin events can wake it
   assign wake_stop = ext_req || kbd_req || lvi_req;
   assign wake_wait = ext_req || kbd_req || lvi_req || ct_req || pt_req;
   // a software-routine low-voltage event does not go to the interrupt line
   assign ord_req = ext_req || kbd_req || (lvi_req && !s_q.ctrl[`LPSW_CTRL_LVI_SOFT])
                    || ct_req || pt_req;
   assign stop_go = stop_exec && !s_q.ctrl[`LPSW_CTRL_STOP_DIS];

   ////////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      s_d = s_q;
      ev = '0;
      w1c = '0;
      rd_val = 32'h0000_0000;
      s_d.clr_imask = 1'b0;
      s_d.lvi_soft = 1'b0;
      s_d.cpu_irq = 1'b0;

      // write data phase; writes land before reads so back to back reads see them
      if (s_q.a_wr) begin
         case (s_q.a_addr)
            `LPSW_ADDR_CTRL: s_d.ctrl = hwdata[7:0];
            `LPSW_ADDR_PC_DIR: s_d.pc_dir = hwdata[7:0];
            `LPSW_ADDR_PC_TMR: s_d.pc_tmr = hwdata[1:0];
            `LPSW_ADDR_IRQ_STAT: w1c = hwdata[`LPSW_EV_W-1:0];
            `LPSW_ADDR_IRQ_MASK: s_d.irq_mask = hwdata[`LPSW_EV_W-1:0];
            default: ;
         endcase
      end
      s_d.a_wr = 1'b0;

      // sleep sequencing
      unique case (s_q.mode)
         st_run: begin
            if (stop_go) begin
               s_d.mode = st_stop;
               s_d.osc_en = 1'b0;
               s_d.periph_run = 1'b0;
               s_d.adc_run = 1'b0;
               s_d.cpu_halt = 1'b1;
               s_d.hold_regs = 1'b1;
               s_d.clr_imask = 1'b1;
               ev[`LPSW_EV_STOP_ENTER] = 1'b1;
            end else if (stop_exec) begin
               ev[`LPSW_EV_STOP_NOP] = 1'b1;
            end else if (wait_exec) begin
               s_d.mode = st_wait;
               s_d.cpu_halt = 1'b1;
               s_d.clr_imask = 1'b1;
               ev[`LPSW_EV_WAIT_ENTER] = 1'b1;
            end
            s_d.cpu_irq = ord_req;
         end
         st_wait: begin
            // timers and converter stay on; only the cpu is held
            if (wake_wait) begin
               s_d.mode = st_run;
               s_d.cpu_halt = 1'b0;
               ev[`LPSW_EV_WAIT_EXIT] = 1'b1;
               s_d.wake = ext_req ? wk_ext : kbd_req ? wk_kbd : lvi_req ? wk_lvi :
                          ct_req ? wk_ctim : wk_ptim;
            end
            s_d.cpu_irq = ord_req;
         end
         st_stop: begin
            // registers, memory and pins are frozen with the oscillator
            if (wake_stop) begin
               s_d.mode = st_startup;
               s_d.osc_en = 1'b1;
               s_d.cnt = '0;
               s_d.pend = ord_req;
               s_d.wake = ext_req ? wk_ext : kbd_req ? wk_kbd : wk_lvi;
            end
         end
         st_startup: begin
            // count whole bus cycles so the delay tracks the bus clock
            if (bus_tick) begin
               if (s_q.cnt == STARTUP_BUS_CYCLES - `LPSW_CNT_W'(1)) begin
                  s_d.mode = st_run;
                  s_d.cpu_halt = 1'b0;
                  s_d.periph_run = 1'b1;
                  s_d.adc_run = 1'b1;
                  s_d.hold_regs = 1'b0;
                  s_d.cpu_irq = s_q.pend;
                  s_d.pend = 1'b0;
                  ev[`LPSW_EV_STOP_EXIT] = 1'b1;
               end else begin
                  s_d.cnt = s_q.cnt + `LPSW_CNT_W'(1);
               end
            end
         end
      endcase

      // low-voltage event raised as software routine request when so chosen
      s_d.lvi_soft = lvi_req && s_q.ctrl[`LPSW_CTRL_LVI_SOFT];

      // sticky events: a set in the clear cycle wins
      s_d.irq_stat = (s_q.irq_stat & ~w1c) | ev;
      s_d.irq = (s_d.irq_stat & s_d.irq_mask) != '0;

      // address phase; zero wait, read data registered for the data phase
      if (hsel && hready && htrans[1]) begin
         s_d.a_wr = hwrite;
         s_d.a_addr = haddr[7:0];
         if (!hwrite) begin
            case (haddr[7:0])
               `LPSW_ADDR_CTRL: rd_val = {24'h00_0000, s_d.ctrl};
               `LPSW_ADDR_PC_DIR: rd_val = {24'h00_0000, s_d.pc_dir};
               `LPSW_ADDR_PC_TMR: rd_val = {30'h0000_0000, s_d.pc_tmr};
               `LPSW_ADDR_STATUS: rd_val = {25'h000_0000, s_q.cpu_halt, s_q.osc_en,
                                            s_q.wake, s_q.mode};
               `LPSW_ADDR_IRQ_STAT: rd_val = {27'h000_0000, s_d.irq_stat};
               `LPSW_ADDR_IRQ_MASK: rd_val = {27'h000_0000, s_d.irq_mask};
               default: rd_val = 32'h0000_0000;
            endcase
            s_d.hrdata = rd_val;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_q <= '0;
         s_q.ctrl <= `LPSW_CTRL_RST;
         s_q.pc_dir <= `LPSW_PC_DIR_RST;
         s_q.pc_tmr <= `LPSW_PC_TMR_RST;
         s_q.irq_stat <= `LPSW_IRQ_RST;
         s_q.irq_mask <= `LPSW_IRQ_RST;
         s_q.hreadyout <= 1'b1;
         s_q.osc_en <= 1'b1;
         s_q.periph_run <= 1'b1;
         s_q.adc_run <= 1'b1;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state register
   assign hreadyout = s_q.hreadyout;
   assign hresp = s_q.hresp;
   assign hrdata = s_q.hrdata;
   assign osc_enable = s_q.osc_en;
   assign cpu_halt = s_q.cpu_halt;
   assign periph_run = s_q.periph_run;
   assign adc_run = s_q.adc_run;
   assign hold_regs = s_q.hold_regs;
   assign clear_imask = s_q.clr_imask;
   assign cpu_irq = s_q.cpu_irq;
   assign lvi_soft_req = s_q.lvi_soft;
   assign irq = s_q.irq;

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   property p_stop_osc;
      @(posedge core_clk) disable iff (rst)
      clk_en && s_q.mode == st_run && stop_go |=> !osc_enable && !periph_run && cpu_halt;
   endproperty
   a_stop_osc: assert property (p_stop_osc) else $error("stop left oscillator on");

   property p_stop_imask;
      @(posedge core_clk) disable iff (rst)
      clk_en && s_q.mode == st_run && stop_go |=> clear_imask ##1 !clear_imask || !clk_en;
   endproperty
   a_stop_imask: assert property (p_stop_imask) else $error("stop entry mask clear");

   property p_stop_hold;
      @(posedge core_clk) disable iff (rst)
      s_q.mode == st_stop |-> hold_regs && !osc_enable && !adc_run;
   endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("stop not holding state");

   property p_stop_wake;
      @(posedge core_clk) disable iff (rst)
      s_q.mode == st_stop && !ext_req && !lvi_req && !kbd_req |=> s_q.mode == st_stop;
   endproperty
   a_stop_wake: assert property (p_stop_wake) else $error("stop left without cause");

   property p_stop_nop;
      @(posedge core_clk) disable iff (rst)
      clk_en && s_q.mode == st_run && stop_exec && s_q.ctrl[`LPSW_CTRL_STOP_DIS]
      |=> s_q.mode == st_run && osc_enable;
   endproperty
   a_stop_nop: assert property (p_stop_nop) else $error("disabled stop entered");

   property p_startup_len;
      @(posedge core_clk) disable iff (rst)
      $past(s_q.mode) == st_startup && s_q.mode == st_run
      |-> $past(s_q.cnt) == STARTUP_BUS_CYCLES - `LPSW_CNT_W'(1) && $past(bus_tick);
   endproperty
   a_startup_len: assert property (p_startup_len) else $error("stop exit delay wrong");

   property p_startup_held;
      @(posedge core_clk) disable iff (rst)
      s_q.mode == st_startup |-> cpu_halt && osc_enable;
   endproperty
   a_startup_held: assert property (p_startup_held) else $error("cpu ran in startup");

   property p_wait_run;
      @(posedge core_clk) disable iff (rst)
      s_q.mode == st_wait |-> cpu_halt && periph_run && adc_run && osc_enable;
   endproperty
   a_wait_run: assert property (p_wait_run) else $error("wait stopped a peripheral");

   property p_wait_wake;
      @(posedge core_clk) disable iff (rst)
      clk_en && s_q.mode == st_wait && ct_req |=> s_q.mode == st_run && !cpu_halt;
   endproperty
   a_wait_wake: assert property (p_wait_wake) else $error("timer did not end wait");

   property p_wait_imask;
      @(posedge core_clk) disable iff (rst)
      clk_en && s_q.mode == st_run && !stop_exec && wait_exec
      |=> clear_imask && s_q.mode == st_wait;
   endproperty
   a_wait_imask: assert property (p_wait_imask) else $error("wait entry wrong");

   property p_kbd_gate;
      @(posedge core_clk) disable iff (rst)
      s_q.mode == st_stop && !ext_req && !lvi_req && ((kbd_fall & kbd_ok) == 8'h00)
      |=> s_q.mode == st_stop;
   endproperty
   a_kbd_gate: assert property (p_kbd_gate) else $error("masked key pin woke stop");

   property p_bus_half;
      @(posedge core_clk) disable iff (rst)
      clk_en && bus_tick |=> !bus_tick;
   endproperty
   a_bus_half: assert property (p_bus_half) else $error("bus tick too fast");

   property p_irq_level;
      @(posedge core_clk) disable iff (rst)
      clk_en && s_q.mode == st_stop && s_q.ctrl[`LPSW_CTRL_IRQ_LEVEL] && !irq_pin_n
      |=> s_q.mode == st_startup;
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("low level did not wake");

   property p_lvi_soft;
      @(posedge core_clk) disable iff (rst)
      clk_en && lvi_req && s_q.ctrl[`LPSW_CTRL_LVI_SOFT] |=> lvi_soft_req;
   endproperty
   a_lvi_soft: assert property (p_lvi_soft) else $error("lvi routine not raised");

   property p_run_quiet;
      @(posedge core_clk) disable iff (rst)
      clk_en && s_q.mode == st_run && !stop_exec && !wait_exec
      |=> s_q.mode == st_run && cpu_irq == $past(ord_req);
   endproperty
   a_run_quiet: assert property (p_run_quiet) else $error("wake event moved run mode");

   c_stop_cycle: cover property (@(posedge core_clk) disable iff (rst)
      s_q.mode == st_startup ##1 s_q.mode == st_run);
   c_wait_cycle: cover property (@(posedge core_clk) disable iff (rst)
      s_q.mode == st_wait ##1 s_q.mode == st_run);
   c_stop_nop: cover property (@(posedge core_clk) disable iff (rst)
      s_q.mode == st_run && stop_exec && s_q.ctrl[`LPSW_CTRL_STOP_DIS]);
endmodule

// ### lpsw_cpu_model.sv
// cpu core and timer request model facing the low-power stop/wait controller
// assumes bench request levels change by non-blocking assignment after core_clk rises
`timescale 1ns/1ps
module lpsw_cpu_model (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // requests from the bench
   input wire logic stop_req,
   input wire logic wait_req,
   input wire logic tmr_req,
   // from the controller
   input wire logic cpu_halt,
   input wire logic clear_imask,
   input wire logic cpu_irq,
   // to the controller; imask_q to the bench
   output logic stop_exec,
   output logic wait_exec,
   output logic core_timer_irq,
   output logic imask_q
);
   ////////////////////////////////////////////////////////////////////////////////
   // instruction strobes, timer level and the condition_code_register mask bit
   always_ff @(posedge core_clk) begin
      if (rst) begin
         stop_exec <= 1'b0;
         wait_exec <= 1'b0;
         core_timer_irq <= 1'b0;
         imask_q <= 1'b1;
      end else begin
         // a halted core executes nothing, so no strobe while halted
         stop_exec <= stop_req & ~cpu_halt;
         wait_exec <= wait_req & ~cpu_halt;
         // timer keeps asking even in stop; the controller must ignore it
         core_timer_irq <= tmr_req;
         if (clear_imask) begin
            imask_q <= 1'b0;
         end else if (cpu_irq) begin
            imask_q <= 1'b1; // servicing sets the mask again
         end
      end
   end
endmodule

// ### tb_low_power_stop_wait_control.sv
// self-checking bench of the low-power stop/wait controller
// assumes lpsw_pkg and lpsw_cpu_model are compiled first; one 200 MHz clock
`timescale 1ns/1ps
module tb_low_power_stop_wait_control;
   typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] r0; logic [31:0] r1;} lpsw_row_t;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic clk_en = 1'b1;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic stop_req = 1'b0;
   logic wait_req = 1'b0;
   logic tmr_req = 1'b0;
   logic pt_irq = 1'b0;
   logic irq_pin_n = 1'b1;
   logic lvi_n = 1'b1;
   logic [7:0] portc = 8'hFF;
   logic hreadyout, hresp, osc_enable, cpu_halt, periph_run, adc_run, hold_regs;
   logic clear_imask, cpu_irq, lvi_soft_req, irq, stop_exec, wait_exec, ct_irq, imask_q;
   logic [31:0] hrdata, rd;
   int error_cnt = 0;
   int samples_checked = 0;
   int cyc = 0;
   int n;
   // ctrl, pc_dir, pc_tmr, status (ro), irq_stat (w1c), irq_mask, unmapped
   lpsw_row_t rows [7] = '{'{8'h00, 32'h7F, 32'h0, 32'h7F}, '{8'h04, 32'hFF, 32'h0, 32'hFF},
      '{8'h08, 32'hFF, 32'h0, 32'h3}, '{8'h0C, 32'hFF, 32'h20, 32'h20},
      '{8'h10, 32'h1F, 32'h0, 32'h0}, '{8'h14, 32'hFF, 32'h0, 32'h1F},
      '{8'h18, 32'hFF, 32'h0, 32'h0}};

   ////////////////////////////////////////////////////////////////////////////////
   // short startup count keeps the stop exit walk brief
   lpsw_ctrl #(.STARTUP_BUS_CYCLES(13'h4)) i_dut (.core_clk(core_clk), .rst(rst),
      .clk_en(clk_en), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .stop_exec(stop_exec), .wait_exec(wait_exec),
      .irq_pin_n(irq_pin_n), .low_voltage_indicator_n(lvi_n), .portc_pin(portc),
      .core_timer_irq(ct_irq), .prog_timer_irq(pt_irq), .osc_enable(osc_enable),
      .cpu_halt(cpu_halt), .periph_run(periph_run), .adc_run(adc_run),
      .hold_regs(hold_regs), .clear_imask(clear_imask), .cpu_irq(cpu_irq),
      .lvi_soft_req(lvi_soft_req), .irq(irq));
   lpsw_cpu_model i_cpu (.core_clk(core_clk), .rst(rst), .stop_req(stop_req),
      .wait_req(wait_req), .tmr_req(tmr_req), .cpu_halt(cpu_halt),
      .clear_imask(clear_imask), .cpu_irq(cpu_irq), .stop_exec(stop_exec),
      .wait_exec(wait_exec), .core_timer_irq(ct_irq), .imask_q(imask_q));

   ////////////////////////////////////////////////////////////////////////////////
   // clock and hang guard
   always #2.5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         complete_run();
      end
   end

   task automatic complete_run();
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   // single word transfer; read data taken at the edge ending the data phase
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic wait_for(ref logic s, input logic v);
      n = 0;
      while (s !== v && n < 40) begin
         @(posedge core_clk);
         n++;
      end
   endtask

   task automatic sleep(input logic stp);
      bus(1'b1, 8'h10, 32'h1F);
      stop_req <= stp;
      wait_req <= ~stp;
      @(posedge core_clk);
      stop_req <= 1'b0;
      wait_req <= 1'b0;
      wait_for(cpu_halt, 1'b1);
      // one more edge so the mask bit cleared by the pulse has landed in the model
      @(posedge core_clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      foreach (rows[i]) begin
         bus(1'b0, rows[i].a, 32'h0);
         chk($sformatf("reset %h", rows[i].a), rows[i].r0, rd);
         bus(1'b1, rows[i].a, rows[i].w);
         bus(1'b0, rows[i].a, 32'h0);
         chk($sformatf("reg %h", rows[i].a), rows[i].r1, rd);
      end
      foreach (rows[i]) bus(1'b1, rows[i].a, 32'h0);
      // timer request in run is ordinary, then wakes wait
      bus(1'b1, 8'h00, 32'h20);
      tmr_req <= 1'b1;
      repeat (4) @(posedge core_clk);
      chk("run halt", 0, cpu_halt);
      tmr_req <= 1'b0;
      repeat (2) @(posedge core_clk);
      sleep(1'b0);
      chk("wait halt", 1, cpu_halt);
      chk("wait periph", 3, {periph_run, adc_run});
      chk("wait imask", 0, imask_q);
      // clock enable low freezes the waiting controller
      clk_en <= 1'b0;
      tmr_req <= 1'b1;
      repeat (6) @(posedge core_clk);
      chk("frozen", 1, cpu_halt);
      clk_en <= 1'b1;
      wait_for(cpu_halt, 1'b0);
      chk("wait wake", 1, n < 6);
      tmr_req <= 1'b0;
      // held low pin wakes only in level mode
      bus(1'b1, 8'h00, 32'h0);
      irq_pin_n <= 1'b0;
      sleep(1'b0);
      repeat (10) @(posedge core_clk);
      chk("edge mode", 1, cpu_halt);
      bus(1'b1, 8'h00, 32'h2);
      wait_for(cpu_halt, 1'b0);
      chk("level mode", 1, n < 6);
      irq_pin_n <= 1'b1;
      // output pin and compare pin give no key, a plain input does
      bus(1'b1, 8'h00, 32'h4);
      bus(1'b1, 8'h04, 32'h1);
      bus(1'b1, 8'h08, 32'h2);
      sleep(1'b0);
      portc <= 8'hFC;
      repeat (10) @(posedge core_clk);
      chk("key excluded", 1, cpu_halt);
      portc <= 8'hF8;
      wait_for(cpu_halt, 1'b0);
      chk("key wake", 1, n < 6);
      portc <= 8'hFF;
      bus(1'b1, 8'h04, 32'h0);
      // stop, timers refused, key wakes, startup delay, interrupt
      bus(1'b1, 8'h00, 32'h64);
      bus(1'b1, 8'h14, 32'h4);
      sleep(1'b1);
      chk("stop clocks", 32'h1, {osc_enable, periph_run, adc_run, hold_regs});
      chk("stop imask", 0, imask_q);
      tmr_req <= 1'b1;
      pt_irq <= 1'b1;
      repeat (20) @(posedge core_clk);
      chk("stop timer", 0, osc_enable);
      portc <= 8'hFB;
      wait_for(osc_enable, 1'b1);
      chk("osc on", 1, n < 6);
      wait_for(cpu_halt, 1'b0);
      chk("startup", 1, n >= 6 && n <= 10);
      chk("resume", 32'h7, {hold_regs, periph_run, adc_run, osc_enable});
      tmr_req <= 1'b0;
      pt_irq <= 1'b0;
      portc <= 8'hFF;
      bus(1'b0, 8'h10, 32'h0);
      chk("stat", 32'h5, rd);
      chk("irq on", 1, irq);
      bus(1'b1, 8'h14, 32'h0);
      repeat (2) @(posedge core_clk);
      chk("irq masked", 0, irq);
      bus(1'b1, 8'h10, 32'h1F);
      bus(1'b0, 8'h10, 32'h0);
      chk("stat clear", 0, rd);
      // disabled stop is a no operation
      bus(1'b1, 8'h00, 32'h1);
      sleep(1'b1);
      chk("stop nop", 32'h1, {cpu_halt, osc_enable});
      bus(1'b0, 8'h10, 32'h0);
      chk("nop stat", 32'h10, rd);
      // held low pin in level mode also ends stop, then the exit delay runs
      bus(1'b1, 8'h00, 32'h2);
      irq_pin_n <= 1'b0;
      sleep(1'b1);
      wait_for(cpu_halt, 1'b0);
      chk("level stop", 1, n >= 6 && n <= 10);
      irq_pin_n <= 1'b1;
      // low voltage in software routine mode
      bus(1'b1, 8'h00, 32'h18);
      lvi_n <= 1'b0;
      wait_for(lvi_soft_req, 1'b1);
      chk("lvi soft", 1, n < 6);
      lvi_n <= 1'b1;
      // interrupt mode sends the event to the cpu instead
      bus(1'b1, 8'h00, 32'h8);
      lvi_n <= 1'b0;
      wait_for(cpu_irq, 1'b1);
      chk("lvi irq", 1, n < 6);
      lvi_n <= 1'b1;
      // reset ends stop
      bus(1'b1, 8'h00, 32'h0);
      sleep(1'b1);
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      chk("reset wake", 32'h1, {cpu_halt, osc_enable});
      complete_run();
   end
endmodule
